/* pkg/cgd_defs.svh */
`ifndef CGD_DEFS_SVH
`define CGD_DEFS_SVH
// ----------------------------------------
// Register select codes and reset values
// ----------------------------------------
`define CGD_SEL_FIELD_GAIN 1'b0
`define CGD_SEL_EXP_SIGN 1'b1
`define CGD_FIELD_GAIN_RST 8'h00
`define CGD_EXP_SIGN_RST 8'h00
// ----------------------------------------
// Field positions, first register
// ----------------------------------------
`define CGD_AUTO_BIT 0
`define CGD_COARSE_LSB 1
`define CGD_FIELD_LSB 4
`define CGD_GAIN_LSB 6
// ----------------------------------------
// Field positions, second register
// ----------------------------------------
`define CGD_EXPDLY_BIT 0
`define CGD_SHIFT_BIT 1
`define CGD_LSDLY_LSB 2
`define CGD_SIGNED_BIT 4
`define CGD_FINE_LSB 5
// ----------------------------------------
// Timing counts in pixel clocks; sum shift in bits
// ----------------------------------------
`define CGD_MARKER_BASE 7'h1d
`define CGD_COARSE_STEP 8
`define CGD_EXP_DELAY 4
`define CGD_LS_STEP 4
`define CGD_LS_MAX 12
`define CGD_SUM_SHIFT 8
`endif

/* pkg/cgd_pkg.sv */
package cgd_pkg;
    typedef enum logic [1:0] {
        CGD_GAIN_BYPASS = 2'b00,
        CGD_GAIN_NORMAL = 2'b01,
        CGD_GAIN_SAT = 2'b10,
        CGD_GAIN_CLAMP = 2'b11
    } cgd_gain_e;
    typedef enum logic {
        CGD_MK_IDLE = 1'b0,
        CGD_MK_COUNT = 1'b1
    } cgd_mk_state_e;
    typedef logic [31:0] cgd_word_t;
endpackage

/* pkg/cgd_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cgd_stream_if #(
    parameter int W = 32
);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

/* logic/cgd_buf2.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Two-entry buffer; full ready, no bubble
// ----------------------------------------
module cgd_buf2 #(
    parameter int W = 32
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    cgd_stream_if.snk in_s,
    cgd_stream_if.src out_s
);
    logic [W-1:0] mem_q [2];
    logic [W-1:0] mem_d [2];
    logic [1:0] cnt_q, cnt_d;
    logic rd_q, rd_d;
    logic wr_q, wr_d;
    logic push, pop;

    assign in_s.ready = (cnt_q != 2'd2);
    assign out_s.valid = (cnt_q != 2'd0);
    assign out_s.data = mem_q[rd_q];
    assign push = in_s.valid && in_s.ready;
    assign pop = out_s.valid && out_s.ready;

    always_comb begin
        mem_d = mem_q;
        cnt_d = cnt_q;
        rd_d = rd_q;
        wr_d = wr_q;
        if (push) begin
            mem_d[wr_q] = in_s.data;
            wr_d = ~wr_q;
        end
        if (pop) begin
            rd_d = ~rd_q;
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 2'd1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 2'd1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mem_q[0] <= '0;
            mem_q[1] <= '0;
            cnt_q <= 2'd0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else begin
            mem_q <= mem_d;
            cnt_q <= cnt_d;
            rd_q <= rd_d;
            wr_q <= wr_d;
        end
    end
endmodule
`default_nettype wire

/* logic/cgd_output_cfg.sv */
`timescale 1ns/1ps
`default_nettype none
`include "cgd_defs.svh"
module cgd_output_cfg #(
    parameter int PIX_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cfg_wr_en,
    input wire logic cfg_wr_sel,
    input wire logic [7:0] cfg_wr_data,
    output logic [7:0] field_gain_marker_coarse_config,
    output logic [7:0] expansion_delay_sign_config,
    input wire logic line_sync_in,
    output logic delayed_line_marker_out,
    input wire logic sum_valid,
    output logic sum_ready,
    input wire cgd_pkg::cgd_word_t sum_data,
    input wire logic [15:0] cascade_sum_bus,
    output logic res_valid,
    input wire logic res_ready,
    output cgd_pkg::cgd_word_t res_data,
    output logic out_mux_allowed,
    input wire logic [PIX_W-1:0] pix_a_in,
    input wire logic [PIX_W-1:0] pix_b_in,
    output logic [PIX_W:0] pix_a_store,
    output logic [PIX_W:0] pix_b_store
);
    import cgd_pkg::*;

    // ----------------------------------------
    // Configuration registers
    // ----------------------------------------
    logic [7:0] cfg_c_q, cfg_c_d, cfg_d_q, cfg_d_d;
    logic auto_sel, exp_dly, sum_shift, pix_signed;
    logic [2:0] coarse, fine;
    logic [1:0] man_sel, ls_code;
    cgd_gain_e gain_mode;

    assign auto_sel = cfg_c_q[`CGD_AUTO_BIT];
    assign coarse = cfg_c_q[`CGD_COARSE_LSB +: 3];
    assign man_sel = cfg_c_q[`CGD_FIELD_LSB +: 2];
    assign gain_mode = cgd_gain_e'(cfg_c_q[`CGD_GAIN_LSB +: 2]);
    assign exp_dly = cfg_d_q[`CGD_EXPDLY_BIT];
    assign sum_shift = cfg_d_q[`CGD_SHIFT_BIT];
    assign ls_code = cfg_d_q[`CGD_LSDLY_LSB +: 2];
    assign pix_signed = cfg_d_q[`CGD_SIGNED_BIT];
    assign fine = cfg_d_q[`CGD_FINE_LSB +: 3];
    assign field_gain_marker_coarse_config = cfg_c_q;
    assign expansion_delay_sign_config = cfg_d_q;

    always_comb begin
        cfg_c_d = cfg_c_q;
        cfg_d_d = cfg_d_q;
        if (cfg_wr_en && cfg_wr_sel == `CGD_SEL_FIELD_GAIN) begin
            cfg_c_d = cfg_wr_data;
        end
        if (cfg_wr_en && cfg_wr_sel == `CGD_SEL_EXP_SIGN) begin
            cfg_d_d = cfg_wr_data;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg_c_q <= `CGD_FIELD_GAIN_RST;
            cfg_d_q <= `CGD_EXP_SIGN_RST;
        end else begin
            cfg_c_q <= cfg_c_d;
            cfg_d_q <= cfg_d_d;
        end
    end

    // ----------------------------------------
    // Line sync synchroniser and marker delay
    // ----------------------------------------
    logic sy1_q, sy2_q, sy3_q, sync_lvl_q, sync_lvl_d;
    logic sync_rise;
    cgd_mk_state_e mk_q, mk_d;
    logic [6:0] mk_cnt_q, mk_cnt_d;
    logic mk_out_q, mk_out_d;

    function automatic logic [6:0] marker_target(input logic [2:0] c, input logic [2:0] f);
        marker_target = `CGD_MARKER_BASE + 7'(c) * 7'(`CGD_COARSE_STEP) + 7'(f);
    endfunction

    // A change counts only once the second and third stages agree
    always_comb begin
        sync_lvl_d = sync_lvl_q;
        if (sy2_q == sy3_q) begin
            sync_lvl_d = sy3_q;
        end
    end
    assign sync_rise = sync_lvl_d && !sync_lvl_q;

    always_comb begin
        mk_d = mk_q;
        mk_cnt_d = mk_cnt_q;
        mk_out_d = 1'b0;
        unique case (mk_q)
            CGD_MK_IDLE: begin
                if (sync_rise) begin
                    mk_d = CGD_MK_COUNT;
                    mk_cnt_d = 7'd1;
                end
            end
            CGD_MK_COUNT: begin
                if (sync_rise) begin
                    mk_cnt_d = 7'd1;
                end else if (mk_cnt_q == marker_target(coarse, fine) - 7'd1) begin
                    mk_out_d = 1'b1;
                    mk_d = CGD_MK_IDLE;
                end else begin
                    mk_cnt_d = mk_cnt_q + 7'd1;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sy1_q <= 1'b0;
            sy2_q <= 1'b0;
            sy3_q <= 1'b0;
            sync_lvl_q <= 1'b0;
            mk_q <= CGD_MK_IDLE;
            mk_cnt_q <= 7'd0;
            mk_out_q <= 1'b0;
        end else begin
            sy1_q <= line_sync_in;
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            sync_lvl_q <= sync_lvl_d;
            mk_q <= mk_d;
            mk_cnt_q <= mk_cnt_d;
            mk_out_q <= mk_out_d;
        end
    end
    assign delayed_line_marker_out = mk_out_q;

    // ----------------------------------------
    // Pixel delay ahead of the line stores
    // ----------------------------------------
    logic [PIX_W-1:0] pa_q [`CGD_LS_MAX], pa_d [`CGD_LS_MAX];
    logic [PIX_W-1:0] pb_q [`CGD_LS_MAX], pb_d [`CGD_LS_MAX];
    logic [PIX_W:0] psa_q, psa_d, psb_q, psb_d;

    function automatic logic [PIX_W:0] pix_ext(input logic [PIX_W-1:0] p, input logic s);
        pix_ext = {s & p[PIX_W-1], p};
    endfunction

    always_comb begin
        pa_d[0] = pix_a_in;
        pb_d[0] = pix_b_in;
        for (int i = 1; i < `CGD_LS_MAX; i++) begin
            pa_d[i] = pa_q[i-1];
            pb_d[i] = pb_q[i-1];
        end
        // Same tap for both sets keeps them aligned
        if (ls_code == 2'b00) begin
            psa_d = pix_ext(pix_a_in, pix_signed);
            psb_d = pix_ext(pix_b_in, pix_signed);
        end else begin
            psa_d = pix_ext(pa_q[4*ls_code-1], pix_signed);
            psb_d = pix_ext(pb_q[4*ls_code-1], pix_signed);
        end
    end

    // Pipeline stages carry no reset: plain data, zero cost in reset fan-out
    always_ff @(posedge ref_clk) begin
        pa_q <= pa_d;
        pb_q <= pb_d;
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            psa_q <= '0;
            psb_q <= '0;
        end else begin
            psa_q <= psa_d;
            psb_q <= psb_d;
        end
    end
    assign pix_a_store = psa_q;
    assign pix_b_store = psb_q;

    // ----------------------------------------
    // Expansion add, field select, gain stage
    // ----------------------------------------
    logic [15:0] xd_q [`CGD_EXP_DELAY], xd_d [`CGD_EXP_DELAY];
    logic [15:0] x_use;
    logic signed [31:0] total;
    logic [1:0] fsel;
    logic signed [19:0] fld;
    cgd_word_t gain_out;

    function automatic logic [1:0] auto_field(input logic [31:0] v);
        if (v[31:19] == {13{v[31]}}) begin
            auto_field = 2'd3;
        end else if (v[31:23] == {9{v[31]}}) begin
            auto_field = 2'd2;
        end else if (v[31:27] == {5{v[31]}}) begin
            auto_field = 2'd1;
        end else begin
            auto_field = 2'd0;
        end
    endfunction

    always_comb begin
        xd_d[0] = cascade_sum_bus;
        for (int i = 1; i < `CGD_EXP_DELAY; i++) begin
            xd_d[i] = xd_q[i-1];
        end
    end

    always_ff @(posedge ref_clk) begin
        xd_q <= xd_d;
    end

    assign x_use = exp_dly ? xd_q[`CGD_EXP_DELAY-1] : cascade_sum_bus;
    // Expansion word follows the pixel signedness
    assign total = (sum_shift ? (sum_data << `CGD_SUM_SHIFT) : sum_data)
                   + {{16{pix_signed & x_use[15]}}, x_use};
    assign fsel = auto_sel ? auto_field(total) : man_sel;
    assign fld = 20'(total >>> (12 - 4 * fsel));

    always_comb begin
        gain_out = total;
        unique case (gain_mode)
            CGD_GAIN_BYPASS: gain_out = total;
            CGD_GAIN_NORMAL: gain_out = cgd_word_t'(fld);
            CGD_GAIN_SAT: begin
                if (fld > 20'sh07fff) begin
                    gain_out = 32'h0000_7fff;
                end else if (fld < -20'sh08000) begin
                    gain_out = 32'hffff_8000;
                end else begin
                    gain_out = cgd_word_t'(fld);
                end
            end
            CGD_GAIN_CLAMP: begin
                if (fld < 0) begin
                    gain_out = 32'h0000_0000;
                end else if (fld > 20'sh07fff) begin
                    gain_out = 32'h0000_7fff;
                end else begin
                    gain_out = cgd_word_t'(fld);
                end
            end
        endcase
    end

    // Only an intermediate device in bypass may multiplex its output
    assign out_mux_allowed = (gain_mode == CGD_GAIN_BYPASS);

    // ----------------------------------------
    // Result buffer
    // ----------------------------------------
    cgd_stream_if #(.W(32)) in_if ();
    cgd_stream_if #(.W(32)) out_if ();

    assign in_if.valid = sum_valid;
    assign in_if.data = gain_out;
    assign sum_ready = in_if.ready;
    assign res_valid = out_if.valid;
    assign res_data = out_if.data;
    assign out_if.ready = res_ready;

    cgd_buf2 #(.W(32)) u_buf (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .in_s(in_if.snk),
        .out_s(out_if.src)
    );
endmodule
`default_nettype wire

/* testbench/cgd_output_cfg_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module cgd_output_cfg_asserts #(
    parameter int PIX_W = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic cfg_wr_en,
    input wire logic cfg_wr_sel,
    input wire logic [7:0] cfg_wr_data,
    input wire logic [7:0] field_gain_marker_coarse_config,
    input wire logic [7:0] expansion_delay_sign_config,
    input wire logic line_sync_in,
    input wire logic delayed_line_marker_out,
    input wire logic sum_valid,
    input wire logic sum_ready,
    input wire cgd_pkg::cgd_word_t sum_data,
    input wire logic [15:0] cascade_sum_bus,
    input wire logic res_valid,
    input wire logic res_ready,
    input wire cgd_pkg::cgd_word_t res_data,
    input wire logic out_mux_allowed,
    input wire logic [PIX_W-1:0] pix_a_in,
    input wire logic [PIX_W-1:0] pix_b_in,
    input wire logic [PIX_W:0] pix_a_store,
    input wire logic [PIX_W:0] pix_b_store
);
    import cgd_pkg::*;
    logic ls_q;
    logic [6:0] cnt_q;
    int t;
    // Pin edge seen here three stages before the design's own detector, so the window is T+2..T+3
    assign t = 29 + 8 * field_gain_marker_coarse_config[3:1] + expansion_delay_sign_config[7:5];
    always_ff @(posedge ref_clk) begin
        ls_q <= line_sync_in;
        if (!rst_n) begin
            cnt_q <= 7'h00;
        end else if (line_sync_in && !ls_q) begin
            cnt_q <= 7'h01;
        end else if (cnt_q != 7'h7f) begin
            cnt_q <= cnt_q + 7'h01;
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_wr_first: assert property (
        cfg_wr_en && !cfg_wr_sel |=> field_gain_marker_coarse_config == $past(cfg_wr_data))
        else $error("first register write lost");
    a_wr_second: assert property (
        cfg_wr_en && cfg_wr_sel |=> expansion_delay_sign_config == $past(cfg_wr_data))
        else $error("second register write lost");
    a_mux_gain: assert property (
        out_mux_allowed == (field_gain_marker_coarse_config[7:6] == 2'b00))
        else $error("output multiplexing wrong for gain mode");
    a_mk_pulse: assert property (delayed_line_marker_out |=> !delayed_line_marker_out)
        else $error("marker longer than one cycle");
    a_mk_delay: assert property (
        delayed_line_marker_out |-> cnt_q >= t + 2 && cnt_q <= t + 3)
        else $error("marker delay off");
    a_res_answer: assert property (sum_valid && sum_ready && !res_valid |=> res_valid)
        else $error("result not offered");
    a_res_hold: assert property (res_valid && !res_ready |=> res_valid && $stable(res_data))
        else $error("stalled result changed");
    a_bypass_sum: assert property (
        sum_valid && sum_ready && !res_valid && {field_gain_marker_coarse_config, expansion_delay_sign_config} == 16'h0
        |=> res_data == $past(sum_data) + {16'h0, $past(cascade_sum_bus)})
        else $error("bypass sum wrong");
    a_pix_store: assert property (expansion_delay_sign_config[3:2] == 2'b00 |=>
        pix_a_store == {$past(expansion_delay_sign_config[4] & pix_a_in[PIX_W-1]), $past(pix_a_in)} &&
        pix_b_store == {$past(expansion_delay_sign_config[4] & pix_b_in[PIX_W-1]), $past(pix_b_in)})
        else $error("undelayed pixel store wrong");
    c_marker: cover property (delayed_line_marker_out);
    c_full: cover property (!sum_ready);
    c_sat: cover property (field_gain_marker_coarse_config[7:6] == 2'b10 && res_valid);
endmodule
bind cgd_output_cfg cgd_output_cfg_asserts #(.PIX_W(PIX_W)) u_chk (.*);
`default_nettype wire

/* testbench/cgd_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cgd_host_model #(
    parameter bit CASCADE_MID = 1'b0
) (
    input wire logic ref_clk,
    output logic cfg_wr_en,
    output logic cfg_wr_sel,
    output logic [7:0] cfg_wr_data
);
    initial begin
        cfg_wr_en = 1'b0;
        cfg_wr_sel = 1'b0;
        cfg_wr_data = 8'h00;
    end
    // Data is scrambled after each strobe so a late sample cannot pass
    task automatic wr(input logic sel, input logic [7:0] d);
        @(negedge ref_clk);
        cfg_wr_en = 1'b1;
        cfg_wr_sel = sel;
        cfg_wr_data = (CASCADE_MID && !sel) ? {2'b00, d[5:0]} : d;
        @(negedge ref_clk);
        cfg_wr_en = 1'b0;
        cfg_wr_data = ~cfg_wr_data;
    endtask
endmodule
`default_nettype wire

/* testbench/convolver_output_gain_delay_config_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module convolver_output_gain_delay_config_tb_top;
    import cgd_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic cfg_wr_en, cfg_wr_sel, delayed_line_marker_out, sum_ready, res_valid, out_mux_allowed;
    logic line_sync_in = 1'b0, sum_valid = 1'b0, res_ready = 1'b0;
    logic [7:0] cfg_wr_data, field_gain_marker_coarse_config, expansion_delay_sign_config;
    cgd_word_t sum_data = 32'h0, res_data;
    logic [15:0] cascade_sum_bus = 16'h0, pix_a_in = 16'h0, pix_b_in = 16'h0;
    logic [16:0] pix_a_store, pix_b_store;
    logic [5:0] mk [3] = '{6'o00, 6'o77, 6'o35};
    int failures = 0, tests_run = 0, n, t;
    cgd_output_cfg #(.PIX_W(16)) dut (.*);
    cgd_host_model host (.*);
    initial forever #5 ref_clk = ~ref_clk;
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge ref_clk);
    endtask
    task automatic cfg(input logic [7:0] c, input logic [7:0] d);
        host.wr(1'b0, c);
        host.wr(1'b1, d);
        check(32'(field_gain_marker_coarse_config), 32'(c));
        check(32'(expansion_delay_sign_config), 32'(d));
    endtask
    // Expansion value xp is held long enough to fill the four-clock delay line
    task automatic res(input logic [7:0] c, d, input cgd_word_t s, input logic [15:0] xp, x, input cgd_word_t e);
        cfg(c, d);
        check(32'(out_mux_allowed), 32'(c[7:6] == 2'b00));
        cascade_sum_bus = xp;
        cyc(6);
        cascade_sum_bus = x;
        sum_data = s;
        sum_valid = 1'b1;
        cyc(1);
        sum_valid = 1'b0;
        sum_data = ~s;
        cascade_sum_bus = ~x;
        check(res_data, e);
        res_ready = 1'b1;
        cyc(1);
        res_ready = 1'b0;
        check(32'(res_valid), 32'h0);
    endtask
    initial begin
        #100us;
        failures++;
        summarize;
    end
    initial begin
        cyc(3);
        rst_n = 1'b1;
        check({12'h0, sum_ready, res_valid, out_mux_allowed, delayed_line_marker_out,
            expansion_delay_sign_config, field_gain_marker_coarse_config}, 32'h000a0000);
        $display("test reset done");
        foreach (mk[i]) begin
            cfg({4'h0, mk[i][5:3], 1'b0}, {mk[i][2:0], 5'h0});
            t = 29 + 8 * mk[i][5:3] + mk[i][2:0];
            line_sync_in = 1'b1;
            n = 0;
            while (delayed_line_marker_out !== 1'b1 && n < 120) begin
                cyc(1);
                n++;
                if (n == 4) line_sync_in = 1'b0;
            end
            check(32'(n >= t + 2 && n <= t + 3), 32'h1);
            cyc(1);
            check(32'(delayed_line_marker_out), 32'h0);
            cyc(10);
        end
        $display("test marker done");
        for (int k = 0; k < 4; k++) begin
            cfg(8'h00, {3'b0, k == 3, k[1:0], 2'b00});
            pix_a_in = 16'h0001;
            pix_b_in = 16'h0001;
            cyc(16);
            pix_a_in = 16'h8000;
            pix_b_in = 16'h8000;
            n = 0;
            while (pix_a_store[15] !== 1'b1 && n < 20) begin
                cyc(1);
                n++;
            end
            check(32'(n), 32'(4 * k + 1));
            check({15'h0, pix_b_store}, {15'h0, k == 3, 16'h8000});
        end
        $display("test pixel done");
        res(8'h00, 8'h00, 32'h00010000, 16'h8001, 16'h8001, 32'h00018001);
        res(8'h00, 8'h02, 32'h12, 16'h34, 16'h34, 32'h1234);
        res(8'h00, 8'h10, 32'h100, 16'hffff, 16'hffff, 32'hff);
        res(8'h00, 8'h01, 32'h0, 16'h11, 16'h22, 32'h11);
        res(8'h40, 8'h00, 32'h01234000, 16'h0, 16'h0, 32'h1234);
        res(8'h50, 8'h00, 32'h00123400, 16'h0, 16'h0, 32'h1234);
        res(8'h60, 8'h00, 32'h00012340, 16'h0, 16'h0, 32'h1234);
        res(8'h70, 8'h00, 32'h00001234, 16'h0, 16'h0, 32'h1234);
        res(8'h41, 8'h00, 32'h00001234, 16'h0, 16'h0, 32'h1234);
        res(8'h30, 8'h00, 32'h12345678, 16'h0, 16'h0, 32'h12345678);
        res(8'h80, 8'h00, 32'h7ffff000, 16'h0, 16'h0, 32'h7fff);
        res(8'h80, 8'h00, 32'h80000000, 16'h0, 16'h0, 32'hffff8000);
        res(8'hc0, 8'h00, 32'h80000000, 16'h0, 16'h0, 32'h0);
        res(8'hc0, 8'h00, 32'h7ffff000, 16'h0, 16'h0, 32'h7fff);
        $display("test result done");
        cfg(8'h00, 8'h00);
        cascade_sum_bus = 16'h0;
        sum_data = 32'h1;
        sum_valid = 1'b1;
        cyc(1);
        sum_data = 32'h2;
        cyc(1);
        sum_valid = 1'b0;
        check(32'(sum_ready), 32'h0);
        res_ready = 1'b1;
        check(res_data, 32'h1);
        cyc(1);
        check(res_data, 32'h2);
        cyc(1);
        res_ready = 1'b0;
        check({sum_ready, res_valid}, 2'b10);
        $display("test buffer done");
        summarize;
    end
endmodule
`default_nettype wire
